// file: hw/guard_defines.svh
`ifndef GUARD_DEFINES_SVH
`define GUARD_DEFINES_SVH

`define GUARD_GROUPS 542
`define GUARD_ADDR_W 25

`define GUARD_OFF_ADDR 8'h00
`define GUARD_OFF_CMD 8'h04
`define GUARD_OFF_PW_LO 8'h08
`define GUARD_OFF_PW_HI 8'h0C
`define GUARD_OFF_STATUS 8'h10

`define GUARD_OP_PROG 4'h1
`define GUARD_OP_ERASE 4'h2
`define GUARD_OP_VOL 4'h3
`define GUARD_OP_CLR_LOCK 4'h4
`define GUARD_OP_UNLOCK 4'h5
`define GUARD_OP_SW_RESET 4'h6
`define GUARD_OP_ARRAY_WR 4'h7
`define GUARD_CMD_DATA_BIT 8

`define GUARD_ST_BUSY 0
`define GUARD_ST_PROG_ERR 1
`define GUARD_ST_PROT_ERR 2
`define GUARD_ST_LOCK 3
`define GUARD_ST_PBIT 4
`define GUARD_ST_VBIT 5
`define GUARD_ST_PROT 6
`define GUARD_ST_PW_MODE 7
`define GUARD_ST_TB 8

`define GUARD_RST_LOCK 1'b0
`define GUARD_RST_VOL 1'b1

`define GUARD_CLK_NS 10
`define GUARD_UNLOCK_US 100
`define GUARD_UNLOCK_CYCLES \
   ((`GUARD_UNLOCK_US * 1000 + `GUARD_CLK_NS - 1) / `GUARD_CLK_NS)
`define GUARD_INIT_CYCLES 3
`define GUARD_PROG_CYCLES 1000
`define GUARD_PREP_CYCLES 200
`define GUARD_ERASE_CYCLES 4000

`endif

// file: hw/guard_pkg.sv
package guard_pkg;
   typedef enum logic [2:0] {
      S_INIT, S_IDLE, S_PROG, S_PRE, S_VERIFY, S_ERASE, S_UNLOCK_WAIT
   } guard_state_t;
   typedef logic [9:0] group_idx_t;
   typedef struct packed {
      logic [3:0] op;
      logic data;
   } guard_cmd_t;
endpackage : guard_pkg

// file: hw/guard_group_map.sv
`timescale 1ns/100ps
`default_nettype none
module guard_group_map (
   input wire logic [24:0] addr,
   input wire logic top_bottom_select,
   output guard_pkg::group_idx_t group
);
   import guard_pkg::*;
   logic [8:0] blk;
   logic [4:0] sec;
   assign blk = addr[24:16];
   assign sec = addr[16:12];
   always_comb begin
      if (top_bottom_select) begin
         if (blk < 9'd2)
            group = {5'b0, sec};
         else
            group = 10'({1'b0, blk} + 10'd30);
      end else begin
         if (blk >= 9'd510)
            group = 10'(10'd510 + {5'b0, sec});
         else
            group = {1'b0, blk};
      end
   end
endmodule : guard_group_map
`default_nettype wire

// file: hw/sector_protection_bits.sv
`timescale 1ns/100ps
`default_nettype none
`include "guard_defines.svh"
// Contract
// - 542 groups: 510 blocks plus 32 end sectors, end chosen by select
// - persistent bits program to zero singly, erase to one all together
// - no single-bit persistent erase; erase takes no address
// - erase does internal pre-program and verify; timed program and erase
// - busy flag readable in status while program or erase runs
// - no array reads while a persistent bit is being programmed
// - persistent bits leave the factory erased to one
// - volatile write sets one group's volatile bit to zero or one
// - group unprotected only when persistent and volatile bits are one
// - volatile bits writable any number of times whatever the lock
// - volatile bits go unprotected on power-up, soft or hard reset
// - lock zero rejects persistent program and erase, bits unchanged
// - persistent mode: lock one at reset, never set again by software
// - password mode: lock zero at reset, set only by good password
// - software reset leaves the lock unchanged
// - bad password sets program and protection errors, lock stays zero
// - bad password holds busy about 100 us; good password skips it
module sector_protection_bits #(
   parameter int unsigned UNLOCK_CYCLES = `GUARD_UNLOCK_CYCLES,
   parameter int unsigned PROG_CYCLES = `GUARD_PROG_CYCLES,
   parameter int unsigned PREP_CYCLES = `GUARD_PREP_CYCLES,
   parameter int unsigned ERASE_CYCLES = `GUARD_ERASE_CYCLES,
   parameter logic [63:0] HIDDEN_PASSWORD = 64'hFFFF_FFFF_FFFF_FFFF
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic hw_reset_pin_n,
   input wire logic password_mode_pin,
   input wire logic top_bottom_pin,
   output logic embedded_op_active,
   output logic array_read_block,
   output logic array_write_go,
   output logic [24:0] array_write_addr
);
   import guard_pkg::*;

   localparam int unsigned GROUPS = `GUARD_GROUPS;

   guard_state_t state;
   guard_state_t next_state;
   logic [31:0] timer;
   logic [1:0] hwr_sync;
   logic [1:0] mode_sync;
   logic [1:0] tb_sync;
   logic hard_reset;
   logic pw_mode;
   logic top_bottom_select;

   logic wr_pend;
   logic [7:0] wr_off;
   logic [24:0] tgt_addr;
   logic [63:0] pw_cand;
   guard_cmd_t cmd;
   group_idx_t tgt_group;
   group_idx_t op_group;

   // nonvolatile cells: initial value models the erased factory state
   logic [GROUPS-1:0] persistent_guard_bit = '1;
   logic [GROUPS-1:0] volatile_guard_bit;
   logic persistent_guard_lock;
   logic prog_err;
   logic protection_error_flag;

   logic wr_cmd;
   logic wr_status;
   logic go;
   logic prog_req;
   logic erase_req;
   logic vol_req;
   logic clear_lock_command;
   logic password_unlock_command;
   logic pw_ok;
   logic swr_req;
   logic arr_req;
   logic p_bit;
   logic v_bit;
   logic group_prot;
   logic err_set;

   // pins from outside the clock domain
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hwr_sync <= 2'b11;
         mode_sync <= 2'b00;
         tb_sync <= 2'b00;
      end else begin
         hwr_sync <= {hwr_sync[0], hw_reset_pin_n};
         mode_sync <= {mode_sync[0], password_mode_pin};
         tb_sync <= {tb_sync[0], top_bottom_pin};
      end
   end
   assign hard_reset = !hwr_sync[1];
   assign pw_mode = mode_sync[1];
   assign top_bottom_select = tb_sync[1];

   guard_group_map u_map (
      .addr(tgt_addr),
      .top_bottom_select(top_bottom_select),
      .group(tgt_group)
   );

   assign p_bit = persistent_guard_bit[tgt_group];
   assign v_bit = volatile_guard_bit[tgt_group];
   assign group_prot = !(p_bit && v_bit);

   function automatic logic [31:0] read_word(input logic [7:0] off);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (off)
         `GUARD_OFF_ADDR: w = {7'b0, tgt_addr};
         `GUARD_OFF_STATUS: begin
            w[`GUARD_ST_BUSY] = embedded_op_active;
            w[`GUARD_ST_PROG_ERR] = prog_err;
            w[`GUARD_ST_PROT_ERR] = protection_error_flag;
            w[`GUARD_ST_LOCK] = persistent_guard_lock;
            w[`GUARD_ST_PBIT] = p_bit;
            w[`GUARD_ST_VBIT] = v_bit;
            w[`GUARD_ST_PROT] = group_prot;
            w[`GUARD_ST_PW_MODE] = pw_mode;
            w[`GUARD_ST_TB] = top_bottom_select;
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction : read_word

   // zero-wait slave; read data sampled in the address phase, so a read
   // right behind a write to the same word returns the older value
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend <= 1'b0;
         wr_off <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= hsel && htrans[1] && hready && hwrite &&
                    (hsize == 3'b010);
         if (hsel && htrans[1] && hready) begin
            wr_off <= haddr[7:0];
            if (!hwrite)
               hrdata <= read_word(haddr[7:0]);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tgt_addr <= '0;
         pw_cand <= '0;
      end else if (wr_pend) begin
         if (wr_off == `GUARD_OFF_ADDR)
            tgt_addr <= hwdata[24:0];
         if (wr_off == `GUARD_OFF_PW_LO)
            pw_cand[31:0] <= hwdata;
         if (wr_off == `GUARD_OFF_PW_HI)
            pw_cand[63:32] <= hwdata;
      end
   end

   assign cmd = {hwdata[3:0], hwdata[`GUARD_CMD_DATA_BIT]};
   assign wr_cmd = wr_pend && (wr_off == `GUARD_OFF_CMD);
   assign wr_status = wr_pend && (wr_off == `GUARD_OFF_STATUS);
   // commands count only when idle; while busy they are dropped
   assign go = wr_cmd && (state == S_IDLE) && !hard_reset;
   assign prog_req = go && (cmd.op == `GUARD_OP_PROG);
   assign erase_req = go && (cmd.op == `GUARD_OP_ERASE);
   assign vol_req = go && (cmd.op == `GUARD_OP_VOL);
   assign clear_lock_command = go && (cmd.op == `GUARD_OP_CLR_LOCK);
   assign password_unlock_command = go && pw_mode &&
                                    (cmd.op == `GUARD_OP_UNLOCK);
   assign swr_req = go && (cmd.op == `GUARD_OP_SW_RESET);
   assign arr_req = go && (cmd.op == `GUARD_OP_ARRAY_WR);
   assign pw_ok = (pw_cand == HIDDEN_PASSWORD);
   assign err_set = ((prog_req || erase_req) && !persistent_guard_lock) ||
                    (password_unlock_command && !pw_ok) ||
                    (arr_req && group_prot);

   function automatic logic [31:0] load_time(input guard_state_t s);
      logic [31:0] t;
      t = 32'h0000_0000;
      case (s)
         S_INIT: t = 32'(`GUARD_INIT_CYCLES);
         S_PROG: t = 32'(PROG_CYCLES - 1);
         S_PRE: t = 32'(PREP_CYCLES - 1);
         S_VERIFY: t = 32'(PREP_CYCLES - 1);
         S_ERASE: t = 32'(ERASE_CYCLES - 1);
         S_UNLOCK_WAIT: t = 32'(UNLOCK_CYCLES - 1);
         default: t = 32'h0000_0000;
      endcase
      return t;
   endfunction : load_time

   always_comb begin
      next_state = state;
      case (state)
         S_INIT:
            if (timer == 32'h0000_0000)
               next_state = S_IDLE;
         S_IDLE: begin
            if (prog_req && persistent_guard_lock)
               next_state = S_PROG;
            else if (erase_req && persistent_guard_lock)
               next_state = S_PRE;
            else if (password_unlock_command && !pw_ok)
               next_state = S_UNLOCK_WAIT;
         end
         S_PROG, S_ERASE, S_UNLOCK_WAIT:
            if (timer == 32'h0000_0000)
               next_state = S_IDLE;
         S_PRE:
            if (timer == 32'h0000_0000)
               next_state = S_VERIFY;
         S_VERIFY:
            if (timer == 32'h0000_0000)
               next_state = S_ERASE;
         default: next_state = S_IDLE;
      endcase
      if (hard_reset)
         next_state = S_INIT;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= S_INIT;
         timer <= 32'(`GUARD_INIT_CYCLES);
         embedded_op_active <= 1'b1;
         array_read_block <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state != state || hard_reset)
            timer <= load_time(next_state);
         else if (timer != 32'h0000_0000)
            timer <= timer - 32'h0000_0001;
         embedded_op_active <= (next_state != S_IDLE);
         array_read_block <= (next_state == S_PROG);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         op_group <= '0;
      else if (prog_req)
         op_group <= tgt_group;
   end

   // no reset term: these cells keep their value across every reset
   always_ff @(posedge sys_clk) begin
      if (state == S_PROG && timer == 32'h0000_0000)
         persistent_guard_bit[op_group] <= 1'b0;
      else if (state == S_ERASE && timer == 32'h0000_0000)
         persistent_guard_bit <= '1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || hard_reset || swr_req)
         volatile_guard_bit <= {GROUPS{`GUARD_RST_VOL}};
      else if (vol_req)
         volatile_guard_bit[tgt_group] <= cmd.data;
   end

   // mode strap is read only after its synchroniser has settled
   always_ff @(posedge sys_clk) begin
      if (!rst_n || hard_reset)
         persistent_guard_lock <= `GUARD_RST_LOCK;
      else if (state == S_INIT && timer == 32'h0000_0000)
         persistent_guard_lock <= !pw_mode;
      else if (clear_lock_command)
         persistent_guard_lock <= 1'b0;
      else if (password_unlock_command && pw_ok)
         persistent_guard_lock <= 1'b1;
   end

   // a new error wins over a clear written in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n || hard_reset) begin
         prog_err <= 1'b0;
         protection_error_flag <= 1'b0;
      end else begin
         prog_err <= err_set ||
            (prog_err && !(wr_status && hwdata[`GUARD_ST_PROG_ERR]));
         protection_error_flag <= err_set ||
            (protection_error_flag &&
             !(wr_status && hwdata[`GUARD_ST_PROT_ERR]));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         array_write_go <= 1'b0;
         array_write_addr <= '0;
      end else begin
         array_write_go <= arr_req && !group_prot;
         if (arr_req)
            array_write_addr <= tgt_addr;
      end
   end

   AST_LOCK_BLOCKS_PPB: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (prog_req || erase_req) && !persistent_guard_lock
      |=> $stable(persistent_guard_bit) && state == S_IDLE && prog_err)
      else $error("persistent change accepted while locked");

   AST_PROG_CLEARS_ONE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      state == S_PROG && timer == 32'h0000_0000 && !hard_reset
      |=> !persistent_guard_bit[$past(op_group)] && state == S_IDLE)
      else $error("program did not clear the persistent bit");

   AST_ERASE_SETS_ALL: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      state == S_ERASE && timer == 32'h0000_0000
      |=> &persistent_guard_bit)
      else $error("erase left a persistent bit at zero");

   AST_ARRAY_GATED: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      arr_req |=> array_write_go == ($past(p_bit) && $past(v_bit)))
      else $error("array write gating wrong");

   AST_SWRST_VOL: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      swr_req |=> &volatile_guard_bit &&
                  persistent_guard_lock == $past(persistent_guard_lock))
      else $error("software reset handled wrongly");

   AST_NO_RELOCK: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      !pw_mode && !persistent_guard_lock && state != S_INIT
      |=> !persistent_guard_lock)
      else $error("lock set again in persistent mode");

   AST_BAD_PW: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      password_unlock_command && !pw_ok
      |=> embedded_op_active && !persistent_guard_lock &&
          protection_error_flag ##1 embedded_op_active)
      else $error("bad password not delayed");

   AST_GOOD_PW: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      password_unlock_command && pw_ok
      |=> persistent_guard_lock && !embedded_op_active)
      else $error("good password did not unlock at once");

   AST_READ_BLOCK: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (state == S_PROG) == array_read_block)
      else $error("array reads not blocked during program");

   AST_VOL_WRITE: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      vol_req && !hard_reset
      |=> volatile_guard_bit[$past(tgt_group)] == $past(cmd.data))
      else $error("volatile bit write lost");
endmodule : sector_protection_bits
`default_nettype wire

// file: verif/flash_array_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic array_write_go,
   input wire logic [24:0] array_write_addr,
   output logic [31:0] n_writes,
   output logic [24:0] last_addr
);
   // only allowed writes may reach the array; count them for the bench
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         n_writes <= 32'h0000_0000;
         last_addr <= 25'h000_0000;
      end else if (array_write_go) begin
         n_writes <= n_writes + 32'h0000_0001;
         last_addr <= array_write_addr;
      end
   end
endmodule : flash_array_model
`default_nettype wire

// file: verif/sector_protection_bits_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sector_protection_bits_tb;
   import guard_pkg::*;
   localparam int UNL = 20;
   localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
   logic sys_clk, rst_n, hsel, hwrite, hw_reset_pin_n;
   logic password_mode_pin, top_bottom_pin, hreadyout, hresp;
   logic embedded_op_active, array_read_block, array_write_go;
   logic [31:0] haddr, hwdata, hrdata, rd, n_writes, w0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [24:0] array_write_addr, last_addr;
   logic [24:0] pa [5] = '{25'h000_0000, 25'h001_0000, 25'h1FF_0000,
      25'h1FF_1000, 25'h1FE_F000};
   logic pv [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   int n_mismatch, checks, n;

   sector_protection_bits #(.UNLOCK_CYCLES(UNL), .PROG_CYCLES(5),
      .PREP_CYCLES(3), .ERASE_CYCLES(5), .HIDDEN_PASSWORD(PW)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .hw_reset_pin_n(hw_reset_pin_n),
      .password_mode_pin(password_mode_pin),
      .top_bottom_pin(top_bottom_pin),
      .embedded_op_active(embedded_op_active),
      .array_read_block(array_read_block),
      .array_write_go(array_write_go), .array_write_addr(array_write_addr));

   flash_array_model far_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .array_write_go(array_write_go), .array_write_addr(array_write_addr),
      .n_writes(n_writes), .last_addr(last_addr));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task results;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // entered just after a rising edge; leaves just after the data edge
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize <= 3'b010;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdc(input logic [31:0] a, input logic [31:0] m,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(rd & m, e);
      check({31'd0, hresp}, 32'h0000_0000);
   endtask : rdc

   task cmd(input logic [3:0] op, input logic v);
      wr(32'h0000_0004, {23'd0, v, 4'd0, op});
   endtask : cmd

   // n ends as the busy length in clocks, bounded
   task idle;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (embedded_op_active !== 1'b0 && n < 50000);
   endtask : idle

   task hard_reset;
      hw_reset_pin_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      hw_reset_pin_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      idle;
   endtask : hard_reset

   function automatic logic [31:0] st(input logic b, input logic e,
      input logic lk, input logic pb, input logic vb, input logic pw,
      input logic tb);
      st = {23'd0, tb, pw, ~(pb & vb), vb, pb, lk, e, e, b};
   endfunction : st

   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      results();
   end

   initial begin
      {rst_n, hsel, hwrite, htrans, hsize} = '0;
      {haddr, hwdata, password_mode_pin, top_bottom_pin} = '0;
      hw_reset_pin_n = 1'b1;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      hsel <= 1'b1;
      idle;
      wr(0, 0);
      rdc(16, '1, st(0, 0, 1, 1, 1, 0, 0));
      $display("test reset state done");
      cmd(3, 0);
      wr(0, 32'h01FF_0000);
      cmd(3, 0);
      for (int i = 0; i < 5; i++) begin
         wr(0, {7'd0, pa[i]});
         rdc(16, '1, st(0, 0, 1, 1, pv[i], 0, 0));
      end
      wr(0, 0);
      cmd(3, 1);
      rdc(16, '1, st(0, 0, 1, 1, 1, 0, 0));
      $display("test group map done");
      wr(0, 32'h0002_0000);
      cmd(1, 0);
      rdc(16, 32'h0000_0001, 32'h0000_0001);
      check({31'd0, array_read_block}, 32'h0000_0001);
      idle;
      rdc(16, '1, st(0, 0, 1, 0, 1, 0, 0));
      w0 = n_writes;
      cmd(7, 0);
      rdc(16, '1, st(0, 1, 1, 0, 1, 0, 0));
      wr(16, 6);
      wr(0, 32'h0003_0000);
      rdc(16, '1, st(0, 0, 1, 1, 1, 0, 0));
      cmd(7, 0);
      repeat (2) @(posedge sys_clk);
      check(n_writes, w0 + 1);
      check({7'd0, last_addr}, 32'h0003_0000);
      cmd(2, 0);
      idle;
      check({31'd0, n >= 11}, 32'h0000_0001);
      wr(0, 32'h0002_0000);
      rdc(16, '1, st(0, 0, 1, 1, 1, 0, 0));
      $display("test program and erase done");
      cmd(4, 0);
      rdc(16, '1, st(0, 0, 0, 1, 1, 0, 0));
      cmd(1, 0);
      idle;
      rdc(16, '1, st(0, 1, 0, 1, 1, 0, 0));
      wr(16, 6);
      wr(8, PW[31:0]);
      wr(12, PW[63:32]);
      cmd(5, 0);
      idle;
      cmd(3, 0);
      rdc(16, '1, st(0, 0, 0, 1, 0, 0, 0));
      cmd(6, 0);
      idle;
      rdc(16, '1, st(0, 0, 0, 1, 1, 0, 0));
      $display("test lock done");
      hard_reset;
      rdc(16, '1, st(0, 0, 1, 1, 1, 0, 0));
      cmd(1, 0);
      idle;
      cmd(4, 0);
      cmd(3, 0);
      hard_reset;
      rdc(16, '1, st(0, 0, 1, 0, 1, 0, 0));
      $display("test hardware reset done");
      password_mode_pin <= 1'b1;
      top_bottom_pin <= 1'b1;
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      idle;
      // group 2 is a bottom sector now; its bit was programmed above
      wr(0, 32'h0000_2000);
      rdc(16, '1, st(0, 0, 0, 0, 1, 1, 1));
      wr(0, 0);
      cmd(3, 0);
      wr(0, 32'h0000_1000);
      rdc(16, '1, st(0, 0, 0, 1, 1, 1, 1));
      wr(8, 0);
      wr(12, 0);
      cmd(5, 0);
      idle;
      check({31'd0, n >= UNL}, 32'h0000_0001);
      rdc(16, '1, st(0, 1, 0, 1, 1, 1, 1));
      wr(16, 6);
      wr(8, PW[31:0]);
      wr(12, PW[63:32]);
      cmd(5, 0);
      idle;
      check({31'd0, n < UNL}, 32'h0000_0001);
      rdc(16, '1, st(0, 0, 1, 1, 1, 1, 1));
      $display("test password done");
      results();
   end
endmodule : sector_protection_bits_tb
`default_nettype wire
